// >>> src/cps_regs.v
// Contract
// - Mask bit7 blocks bus overcurrent interrupt
// - Mask bit6 gates wireless reverse overcurrent interrupt
// - Status bits read-only, follow live conditions
// - Status1 bit4: output voltage present
// - Status1 bit3: bus voltage too low
// - Status1 bit2: wireless input present
// - Status1 bit1: switching, one interrupt per start
// - Status1 bit0: bus voltage present
// - Status2 bit7: bus overvoltage
// - Status2 bit6: output overvoltage
// - Status2 bit3: bus overcurrent
// - Status2 bit2: reverse current toward wireless input
// - Status2 bit1: die over-temperature
// - Status2 bit0: watchdog reset pending, 32 ms
// - Output overvoltage code, default 9 V
// - Bus overvoltage code, default 9 V
// - Overcurrent events latch flags; reading flags clears them
// - Reverse overcurrent flag latched, clear on read
`timescale 1ns/10ps
`default_nettype none

`include "cps_defines.vh"

module cps_regs #(
  parameter [6:0]  DEV_ADDR      = `CPS_DEV_ADDR,
  parameter        WDT_CNT_W     = 22,
  parameter [21:0] WDT_DELAY_CYC = `CPS_WDT_DELAY_CYC
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Serial register port, open drain data
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out_ff,
  output reg        sda_oe_ff,
  // Device resets
  input  wire       reg_reset_req,
  input  wire       wdt_expire,
  output reg        wdt_reset_ff,
  // Live comparator results
  input  wire       output_present_live,
  input  wire       bus_undervoltage_live,
  input  wire       wireless_input_present_live,
  input  wire       converter_switching_live,
  input  wire       bus_present_live,
  input  wire       bus_overvoltage_live,
  input  wire       output_overvoltage_live,
  input  wire       bus_overcurrent_live,
  input  wire       wireless_reverse_overcurrent_live,
  input  wire       die_overtemperature_live,
  // Thresholds to the comparators
  output reg  [2:0] output_overvoltage_threshold_ff,
  output reg  [5:0] bus_overvoltage_threshold_ff,
  // Interrupt, active low
  output reg        int_n_ff
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus states, one hot
  localparam [9:0] S_IDLE  = 10'h001;
  localparam [9:0] S_ADDR  = 10'h002;
  localparam [9:0] S_AACK  = 10'h004;
  localparam [9:0] S_REG   = 10'h008;
  localparam [9:0] S_RACK  = 10'h010;
  localparam [9:0] S_WR    = 10'h020;
  localparam [9:0] S_WACK  = 10'h040;
  localparam [9:0] S_RD    = 10'h080;
  localparam [9:0] S_MACK  = 10'h100;
  localparam [9:0] S_MNEXT = 10'h200;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  reg  rst_sync1_ff;
  reg  rst_sync2_ff;
  wire rst_n_int;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  assign rst_n_int = rst_sync2_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [9:0] state_ff;
  reg  [7:0] shift_ff;
  reg  [3:0] bit_cnt_ff;
  reg  [7:0] ptr_ff;
  reg        rw_ff;
  reg        scl_prev_ff;
  reg        sda_prev_ff;
  reg        bus_oc_block_ff;
  reg        wrx_oc_block_ff;
  reg  [4:0] ins_stat_ff;
  reg  [7:0] prot_stat_ff;
  reg        wdt_pend_ff;
  reg  [WDT_CNT_W-1:0] wdt_cnt_ff;
  reg        clr_flags_ff;
  reg        clr_sw_ff;
  reg  [7:0] rd_data;
  reg        wr_stb;
  wire       bus_oc_flag;
  wire       wrx_oc_flag;
  wire       sw_flag;
  wire       scl_rise;
  wire       scl_fall;
  wire       bus_start;
  wire       bus_stop;
  wire       wdt_fire;
  wire       irq_any;

  //////////////////////////////////////////////////////////////////////////////
  // Live status sampling, untouched by either device reset
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ins_stat_ff  <= 5'h00;
      prot_stat_ff <= 8'h00;
    end else begin
      ins_stat_ff[`CPS_BIT_OUT_PRES]   <= output_present_live;
      ins_stat_ff[`CPS_BIT_BUS_UV]     <= bus_undervoltage_live;
      ins_stat_ff[`CPS_BIT_WRX_PRES]   <= wireless_input_present_live;
      ins_stat_ff[`CPS_BIT_SWITCHING]  <= converter_switching_live;
      ins_stat_ff[`CPS_BIT_BUS_PRES]   <= bus_present_live;
      prot_stat_ff[`CPS_BIT_BUS_OV]    <= bus_overvoltage_live;
      prot_stat_ff[`CPS_BIT_OUT_OV]    <= output_overvoltage_live;
      prot_stat_ff[5:4]                <= 2'h0;
      prot_stat_ff[`CPS_BIT_PS_BUS_OC] <= bus_overcurrent_live;
      prot_stat_ff[`CPS_BIT_PS_WRX_OC] <= wireless_reverse_overcurrent_live;
      prot_stat_ff[`CPS_BIT_DIE_OT]    <= die_overtemperature_live;
      prot_stat_ff[`CPS_BIT_WDT_PEND]  <= wdt_pend_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latched event flags
  cps_flag_latch u_bus_oc_flag (
    .clk     (clk),
    .rst_n   (rst_n_int),
    .live    (prot_stat_ff[`CPS_BIT_PS_BUS_OC]),
    .clr     (clr_flags_ff),
    .flag_ff (bus_oc_flag)
  );

  cps_flag_latch u_wrx_oc_flag (
    .clk     (clk),
    .rst_n   (rst_n_int),
    .live    (prot_stat_ff[`CPS_BIT_PS_WRX_OC]),
    .clr     (clr_flags_ff),
    .flag_ff (wrx_oc_flag)
  );

  // Switching start raises one event per episode
  cps_flag_latch u_sw_flag (
    .clk     (clk),
    .rst_n   (rst_n_int),
    .live    (ins_stat_ff[`CPS_BIT_SWITCHING]),
    .clr     (clr_sw_ff),
    .flag_ff (sw_flag)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog pending window, then the watchdog reset pulse
  assign wdt_fire = wdt_pend_ff && (wdt_cnt_ff == WDT_DELAY_CYC[WDT_CNT_W-1:0] - 1'b1);

  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      wdt_pend_ff  <= 1'b0;
      wdt_cnt_ff   <= {WDT_CNT_W{1'b0}};
      wdt_reset_ff <= 1'b0;
    end else begin
      wdt_reset_ff <= wdt_fire;
      if (wdt_fire) begin
        wdt_pend_ff <= 1'b0;
        wdt_cnt_ff  <= {WDT_CNT_W{1'b0}};
      end else if (wdt_pend_ff) begin
        wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
      end else if (wdt_expire) begin
        wdt_pend_ff <= 1'b1;
        wdt_cnt_ff  <= {WDT_CNT_W{1'b0}};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writable registers and their two reset sources
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      bus_oc_block_ff                 <= `CPS_RST_MASK_BLOCK;
      wrx_oc_block_ff                 <= `CPS_RST_MASK_BLOCK;
      output_overvoltage_threshold_ff <= `CPS_RST_OUT_OV;
      bus_overvoltage_threshold_ff    <= `CPS_RST_BUS_OV;
    end else if (reg_reset_req) begin
      bus_oc_block_ff                 <= `CPS_RST_MASK_BLOCK;
      wrx_oc_block_ff                 <= `CPS_RST_MASK_BLOCK;
      output_overvoltage_threshold_ff <= `CPS_RST_OUT_OV;
      bus_overvoltage_threshold_ff    <= `CPS_RST_BUS_OV;
    end else if (wdt_reset_ff) begin
      output_overvoltage_threshold_ff <= `CPS_RST_OUT_OV;
      bus_overvoltage_threshold_ff    <= `CPS_RST_BUS_OV;
    end else if (wr_stb) begin
      case (ptr_ff)
        `CPS_ADDR_OC_MASK: begin
          bus_oc_block_ff <= shift_ff[`CPS_BIT_BUS_OC];
          wrx_oc_block_ff <= shift_ff[`CPS_BIT_WRX_OC];
        end
        `CPS_ADDR_OUT_OV_LIM: begin
          output_overvoltage_threshold_ff <= shift_ff[2:0];
        end
        `CPS_ADDR_BUS_OV_LIM: begin
          bus_overvoltage_threshold_ff <= shift_ff[5:0];
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux, reserved bits fixed
  always @* begin
    case (ptr_ff)
      `CPS_ADDR_FLAGS:      rd_data = {bus_oc_flag, wrx_oc_flag, 6'h00};
      `CPS_ADDR_OC_MASK:    rd_data = {bus_oc_block_ff, wrx_oc_block_ff, `CPS_MASK_RSVD};
      `CPS_ADDR_INS_STAT:   rd_data = {3'h0, ins_stat_ff};
      `CPS_ADDR_PROT_STAT:  rd_data = prot_stat_ff;
      `CPS_ADDR_OUT_OV_LIM: rd_data = {5'h00, output_overvoltage_threshold_ff};
      `CPS_ADDR_BUS_OV_LIM: rd_data = {2'h0, bus_overvoltage_threshold_ff};
      default:              rd_data = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial line edge and condition detection
  assign scl_rise  = scl_in & ~scl_prev_ff;
  assign scl_fall  = ~scl_in & scl_prev_ff;
  assign bus_start = scl_in & scl_prev_ff & sda_prev_ff & ~sda_in;
  assign bus_stop  = scl_in & scl_prev_ff & ~sda_prev_ff & sda_in;

  // Write strobe fires when the data byte is acknowledged
  always @* begin
    wr_stb = (state_ff == S_WR) && scl_fall && (bit_cnt_ff == 4'h8);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial slave: address, pointer, write and read phases
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_ff     <= S_IDLE;
      shift_ff     <= 8'h00;
      bit_cnt_ff   <= 4'h0;
      ptr_ff       <= 8'h00;
      rw_ff        <= 1'b0;
      scl_prev_ff  <= 1'b1;
      sda_prev_ff  <= 1'b1;
      sda_out_ff   <= 1'b0;
      sda_oe_ff    <= 1'b0;
      clr_flags_ff <= 1'b0;
      clr_sw_ff    <= 1'b0;
    end else begin
      scl_prev_ff  <= scl_in;
      sda_prev_ff  <= sda_in;
      clr_flags_ff <= 1'b0;
      clr_sw_ff    <= 1'b0;
      if (bus_start) begin
        state_ff   <= S_ADDR;
        bit_cnt_ff <= 4'h0;
        sda_oe_ff  <= 1'b0;
      end else if (bus_stop) begin
        state_ff  <= S_IDLE;
        sda_oe_ff <= 1'b0;
      end else begin
        case (state_ff)
          S_IDLE: begin
            sda_oe_ff <= 1'b0;
          end
          S_ADDR, S_REG, S_WR: begin
            if (scl_rise && bit_cnt_ff != 4'h8) begin
              shift_ff   <= {shift_ff[6:0], sda_in};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              sda_oe_ff <= 1'b1;
              if (state_ff == S_ADDR) begin
                if (shift_ff[7:1] == DEV_ADDR) begin
                  rw_ff    <= shift_ff[0];
                  state_ff <= S_AACK;
                end else begin
                  sda_oe_ff <= 1'b0;
                  state_ff  <= S_IDLE;
                end
              end else if (state_ff == S_REG) begin
                ptr_ff   <= shift_ff;
                state_ff <= S_RACK;
              end else begin
                ptr_ff   <= ptr_ff + 8'h01;
                state_ff <= S_WACK;
              end
            end
          end
          S_RACK, S_WACK: begin
            if (scl_fall) begin
              sda_oe_ff  <= 1'b0;
              bit_cnt_ff <= 4'h0;
              state_ff   <= S_WR;
            end
          end
          S_AACK, S_MNEXT: begin
            if (scl_fall && state_ff == S_AACK && !rw_ff) begin
              sda_oe_ff  <= 1'b0;
              bit_cnt_ff <= 4'h0;
              state_ff   <= S_REG;
            end else if (scl_fall) begin
              // Load a byte, the read clears its read-to-clear flags
              shift_ff     <= rd_data;
              sda_oe_ff    <= ~rd_data[7];
              bit_cnt_ff   <= 4'h0;
              ptr_ff       <= ptr_ff + 8'h01;
              clr_flags_ff <= (ptr_ff == `CPS_ADDR_FLAGS);
              clr_sw_ff    <= (ptr_ff == `CPS_ADDR_INS_STAT);
              state_ff     <= S_RD;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (bit_cnt_ff == 4'h7) begin
                sda_oe_ff <= 1'b0;
                state_ff  <= S_MACK;
              end else begin
                shift_ff   <= {shift_ff[6:0], 1'b0};
                sda_oe_ff  <= ~shift_ff[6];
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              state_ff <= sda_in ? S_IDLE : S_MNEXT;
            end
          end
          default: begin
            state_ff  <= S_IDLE;
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt output, low while any unmasked flag stands
  assign irq_any = (bus_oc_flag & ~bus_oc_block_ff)
                 | (wrx_oc_flag & ~wrx_oc_block_ff)
                 | sw_flag;

  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int)
      int_n_ff <= 1'b1;
    else
      int_n_ff <= ~irq_any;
  end

endmodule

`default_nettype wire

// >>> src/cps_defines.vh
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define CPS_ADDR_FLAGS        8'h03
`define CPS_ADDR_OC_MASK      8'h07
`define CPS_ADDR_INS_STAT     8'h08
`define CPS_ADDR_PROT_STAT    8'h09
`define CPS_ADDR_OUT_OV_LIM   8'h0A
`define CPS_ADDR_BUS_OV_LIM   8'h0B

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CPS_BIT_BUS_OC        7
`define CPS_BIT_WRX_OC        6
`define CPS_BIT_OUT_PRES      4
`define CPS_BIT_BUS_UV        3
`define CPS_BIT_WRX_PRES      2
`define CPS_BIT_SWITCHING     1
`define CPS_BIT_BUS_PRES      0
`define CPS_BIT_BUS_OV        7
`define CPS_BIT_OUT_OV        6
`define CPS_BIT_PS_BUS_OC     3
`define CPS_BIT_PS_WRX_OC     2
`define CPS_BIT_DIE_OT        1
`define CPS_BIT_WDT_PEND      0

////////////////////////////////////////////////////////////////////////////////
// Reset values and read-only fill patterns
`define CPS_RST_MASK_BLOCK    1'b1
`define CPS_MASK_RSVD         6'h3F
`define CPS_RST_OUT_OV        3'h2
`define CPS_RST_BUS_OV        6'h07
`define CPS_BUS_OV_MAX        6'h3B

////////////////////////////////////////////////////////////////////////////////
// Bus address and timing
`define CPS_DEV_ADDR          7'h6A
`define CPS_CLK_PERIOD_NS     10
`define CPS_WDT_DELAY_MS      32
`define CPS_WDT_DELAY_CYC     ((`CPS_WDT_DELAY_MS * 1000000) / `CPS_CLK_PERIOD_NS)

`endif

// >>> src/cps_flag_latch.v
`timescale 1ns/10ps
`default_nettype none

// Sticky flag set on the rising edge of a live condition, cleared by a read
module cps_flag_latch (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Condition and clear
  input  wire live,
  input  wire clr,
  // Latched flag
  output reg  flag_ff
);

  reg live_prev_ff;
  wire set_evt;

  assign set_evt = live & ~live_prev_ff;

  // A set arriving with a clear wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_prev_ff <= 1'b0;
      flag_ff      <= 1'b0;
    end else begin
      live_prev_ff <= live;
      if (set_evt)
        flag_ff <= 1'b1;
      else if (clr)
        flag_ff <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> sim/cps_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
// Port checks of the protection register block
module cps_regs_props #(
  parameter [21:0] WDT_DELAY_CYC = 22'h14
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Inputs
  input wire logic       scl_in,
  input wire logic       reg_reset_req,
  input wire logic       wdt_expire,
  input wire logic       bus_overcurrent_live,
  input wire logic       wireless_reverse_overcurrent_live,
  input wire logic       converter_switching_live,
  // Outputs
  input wire logic       sda_out_ff,
  input wire logic       wdt_reset_ff,
  input wire logic       int_n_ff,
  input wire logic [2:0] output_overvoltage_threshold_ff,
  input wire logic [5:0] bus_overvoltage_threshold_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Own copy of the pending state and the cycles spent pending
  logic        pend_ff;
  logic [21:0] cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= 1'b0;
      cnt_ff  <= 22'h0;
    end else if (wdt_reset_ff) begin
      pend_ff <= 1'b0;
    end else if (wdt_expire && !pend_ff) begin
      pend_ff <= 1'b1;
      cnt_ff  <= 22'h0;
    end else if (pend_ff) begin
      cnt_ff <= cnt_ff + 22'h1;
    end
  end
  a_int_cause: assert property (
    $fell(int_n_ff) |-> $past(bus_overcurrent_live | wireless_reverse_overcurrent_live
      | converter_switching_live, 2)) else $error("interrupt without event");
  a_wdt_pulse: assert property (wdt_reset_ff |=> !wdt_reset_ff)
    else $error("watchdog reset too long");
  a_wdt_delay: assert property (
    wdt_reset_ff |-> pend_ff && cnt_ff + 22'h2 >= WDT_DELAY_CYC
      && cnt_ff <= WDT_DELAY_CYC + 22'h1) else $error("watchdog reset mistimed");
  a_wdt_restore: assert property (
    wdt_reset_ff |=> output_overvoltage_threshold_ff == 3'h2
      && bus_overvoltage_threshold_ff == 6'h07) else $error("limits kept after watchdog");
  a_reg_restore: assert property (
    reg_reset_req |=> output_overvoltage_threshold_ff == 3'h2
      && bus_overvoltage_threshold_ff == 6'h07) else $error("limits kept after reset");
  a_out_hold: assert property (
    $changed(output_overvoltage_threshold_ff) |-> !scl_in || $past(wdt_reset_ff)
      || $past(reg_reset_req)) else $error("output limit changed unprompted");
  a_bus_hold: assert property (
    $changed(bus_overvoltage_threshold_ff) |-> !scl_in || $past(wdt_reset_ff)
      || $past(reg_reset_req)) else $error("bus limit changed unprompted");
  a_sda_drain: assert property (sda_out_ff == 1'b0) else $error("data driven high");
endmodule
`default_nettype wire

// >>> sim/cps_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "cps_defines.vh"
// Host master: owns the serial clock, only ever pulls data low
module cps_host_model #(
  parameter logic [6:0] ADDR = `CPS_DEV_ADDR
) (
  // Clock
  input  wire logic clk,
  // Serial lines
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  // Bus idle at time zero
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // One bus phase of six device clocks
  task automatic ph();
    repeat (6) @(negedge clk);
  endtask
  // Data set while clock low, sampled at end of high phase
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    ph();
    scl = 1'b1;
    ph();
    s = sda_line;
    scl = 1'b0;
    ph();
  endtask
  // Start or repeated start
  task automatic start();
    sda_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b0;
    ph();
  endtask
  // Stop
  task automatic stop();
    sda_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b0;
    ph();
  endtask
  // Byte out, most significant bit first, then acknowledge
  task automatic tx(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ok = ok & ~s;
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    tx({ADDR, 1'b0}, ok);
    tx(a, ok);
    tx(d, ok);
    stop();
  endtask
  // Register read of one byte, ended by a missing acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic s;
    ok = 1'b1;
    start();
    tx({ADDR, 1'b0}, ok);
    tx(a, ok);
    start();
    tx({ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, s);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> sim/charger_protect_status_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module charger_protect_status_regs_tb;
  localparam logic [21:0] WDT_DLY = 22'hBB8;
  // Status offset and value per live input
  localparam logic [15:0] STAT_TBL [10] = '{
    16'h0810,
    16'h0808,
    16'h0804,
    16'h0802,
    16'h0801,
    16'h0980,
    16'h0940,
    16'h0908,
    16'h0904,
    16'h0902
  };
  // Stimulus and observed outputs
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_rst = 1'b0;
  logic       wdt_exp = 1'b0;
  logic [9:0] live = 10'h0;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       wdt_rst;
  logic       int_n;
  logic [2:0] out_thr;
  logic [5:0] bus_thr;
  wire        sda = ~(sda_low | sda_oe);
  int         error_cnt = 0;
  int         total_checks = 0;
  always #5 clk = ~clk;
  cps_host_model host_u (.clk(clk), .sda_line(sda), .scl(scl), .sda_low(sda_low));
  cps_regs #(.WDT_DELAY_CYC(WDT_DLY)) dut_u (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out_ff(), .sda_oe_ff(sda_oe),
    .reg_reset_req(reg_rst), .wdt_expire(wdt_exp), .wdt_reset_ff(wdt_rst),
    .output_present_live(live[0]), .bus_undervoltage_live(live[1]),
    .wireless_input_present_live(live[2]), .converter_switching_live(live[3]),
    .bus_present_live(live[4]), .bus_overvoltage_live(live[5]),
    .output_overvoltage_live(live[6]), .bus_overcurrent_live(live[7]),
    .wireless_reverse_overcurrent_live(live[8]), .die_overtemperature_live(live[9]),
    .output_overvoltage_threshold_ff(out_thr), .bus_overvoltage_threshold_ff(bus_thr),
    .int_n_ff(int_n)
  );
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host_u.wr(a, d, ok);
    chk("write ack", {7'h0, ok}, 8'h01);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host_u.rd(a, d, ok);
    chk("read ack", {7'h0, ok}, 8'h01);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic irq(input logic e);
    cyc(8);
    chk("int_n", {7'h0, int_n}, {7'h0, e});
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reset values, reserved fill, unmapped place
  task automatic t_defaults();
    rdc(8'h07, 8'hFF);
    rdc(8'h09, 8'h00);
    rdc(8'h0A, 8'h02);
    rdc(8'h0B, 8'h07);
    rdc(8'h0F, 8'h00);
    irq(1'b1);
  endtask
  // Writable fields, reserved bits, read-only places
  task automatic t_writes();
    wrc(8'h0A, 8'hFF);
    rdc(8'h0A, 8'h07);
    chk("out_thr", {5'h0, out_thr}, 8'h07);
    wrc(8'h0B, 8'hFB);
    rdc(8'h0B, 8'h3B);
    chk("bus_thr", {2'h0, bus_thr}, 8'h3B);
    wrc(8'h07, 8'h00);
    rdc(8'h07, 8'h3F);
    wrc(8'h08, 8'hFF);
    rdc(8'h08, 8'h00);
  endtask
  // Each live input shows in its own bit only while it holds
  task automatic t_status();
    for (int i = 0; i < 10; i++) begin
      live = 10'h1 << i;
      cyc(4);
      rdc(STAT_TBL[i][15:8], STAT_TBL[i][7:0]);
    end
    live = 10'h0;
    cyc(4);
    rdc(8'h09, 8'h00);
    rdc(8'h03, 8'hC0);
    irq(1'b1);
  endtask
  // Mask bits gate the interrupt of each overcurrent flag
  task automatic t_irq();
    wrc(8'h07, 8'h80);
    live[7] = 1'b1;
    irq(1'b1);
    live[8] = 1'b1;
    irq(1'b0);
    live = 10'h0;
    rdc(8'h03, 8'hC0);
    irq(1'b1);
    wrc(8'h07, 8'h40);
    live[8] = 1'b1;
    irq(1'b1);
    live[7] = 1'b1;
    irq(1'b0);
    live = 10'h0;
    rdc(8'h03, 8'hC0);
    irq(1'b1);
  endtask
  // One interrupt per switching start, none while it continues
  task automatic t_switch();
    live[3] = 1'b1;
    irq(1'b0);
    rdc(8'h08, 8'h02);
    cyc(50);
    irq(1'b1);
    live = 10'h0;
  endtask
  // Watchdog expiry, delayed reset, register reset
  task automatic t_wdt();
    int n;
    wrc(8'h0A, 8'h05);
    wrc(8'h0B, 8'h20);
    wdt_exp = 1'b1;
    cyc(1);
    wdt_exp = 1'b0;
    rdc(8'h09, 8'h01);
    n = 0;
    while (wdt_rst !== 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
    chk("wdt reset", {7'h0, wdt_rst}, 8'h01);
    cyc(3);
    chk("out_thr", {5'h0, out_thr}, 8'h02);
    chk("bus_thr", {2'h0, bus_thr}, 8'h07);
    rdc(8'h07, 8'h7F);
    rdc(8'h09, 8'h00);
    wrc(8'h0A, 8'h06);
    reg_rst = 1'b1;
    cyc(1);
    reg_rst = 1'b0;
    rdc(8'h07, 8'hFF);
    rdc(8'h0A, 8'h02);
  endtask
  // Main sequence
  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(5);
    t_defaults();
    t_writes();
    t_status();
    t_irq();
    t_switch();
    t_wdt();
    wrap_up();
  end
  // Hang guard, about twice the expected run of some 30,000 cycles
  initial begin
    #600000;
    error_cnt++;
    wrap_up();
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cps_regs cps_regs_props #(.WDT_DELAY_CYC(WDT_DELAY_CYC)) chk_u (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .reg_reset_req(reg_reset_req),
  .wdt_expire(wdt_expire), .bus_overcurrent_live(bus_overcurrent_live),
  .wireless_reverse_overcurrent_live(wireless_reverse_overcurrent_live),
  .converter_switching_live(converter_switching_live), .sda_out_ff(sda_out_ff),
  .wdt_reset_ff(wdt_reset_ff), .int_n_ff(int_n_ff),
  .output_overvoltage_threshold_ff(output_overvoltage_threshold_ff),
  .bus_overvoltage_threshold_ff(bus_overvoltage_threshold_ff)
);
`default_nettype wire
